/* File: src/srp_policy.sv */
// Restart policy, cascaded power-off and force-shutdown control.
// Assumes monitor levels and fault flags are synchronous to clock.
`timescale 1ns/100ps
// Contract
// - UV, OV or sequence timeout makes the shutdown fault-triggered, unless a force-shutdown comes in the same cycle.
// - Fault shutdowns wait 2.4 s before restart; retries may be capped.
// - Force-shutdown pin, power-on pin or bus command makes it command-triggered; a fault in the same cycle outranks all but force-shutdown.
// - Command shutdowns wait 12.5 ms and do not count as retries.
// - Next position stays enabled until the previous position's channels are off.
// - Channels in the same position are not ordered against each other.
// - Force-shutdown drops every enable at once, ignoring positions.
// - Restarts after fault shutdowns are counted against the retry limit.
// - A power-on delay separates restart timer expiry and each enable.
// - A programmable power-off delay follows each supply being off.
module srp_policy #(
    parameter int     NUM_CH    = srp_pkg::NUM_CH,
    parameter int     NUM_POS   = srp_pkg::NUM_POS,
    parameter longint FAULT_CYC = srp_pkg::FAULT_DLY_CYC,
    parameter longint CMD_CYC   = srp_pkg::CMD_DLY_CYC
) (
    // Clock and reset.
    input  wire logic                                    clock,
    input  wire logic                                    rst_b,
    // Causes.
    input  wire srp_pkg::srp_fault_t                     fault,
    input  wire srp_pkg::srp_cmd_t                       cmd,
    // Configuration.
    input  wire logic [NUM_CH-1:0][srp_pkg::POS_W-1:0]   on_pos,
    input  wire logic [NUM_CH-1:0][srp_pkg::POS_W-1:0]   off_pos,
    input  wire logic [NUM_CH-1:0][srp_pkg::DLY_W-1:0]   on_dly,
    input  wire logic [NUM_CH-1:0][srp_pkg::DLY_W-1:0]   off_dly,
    input  wire logic                                    retry_limit_en,
    input  wire logic [srp_pkg::RETRY_W-1:0]             retry_limit,
    // Monitored supplies, high when below off threshold.
    input  wire logic [NUM_CH-1:0]                       monitored_supply_input_off,
    // Outputs.
    output logic      [NUM_CH-1:0]                       supply_enable_output,
    output logic                                         fault_cause_reg,
    output logic      [srp_pkg::RETRY_W-1:0]             retry_count_reg,
    output logic                                         locked_out,
    output logic                                         running
);
    ////////////////////////////////////////////////////////////////////////////
    srp_pkg::srp_state_t               state_reg;
    logic [srp_pkg::TMR_W-1:0]         tmr_reg;
    logic [srp_pkg::DLY_W-1:0]         on_cnt_reg;
    logic [srp_pkg::POS_W-1:0]         pos_reg;
    logic                              fs_reg;
    logic                              fault_any;
    logic                              cmd_off;
    logic                              cmd_fs;
    logic [NUM_CH-1:0]                 turn_on;
    logic [NUM_CH-1:0]                 turn_off;
    logic [NUM_CH-1:0]                 ch_en;
    logic                              prev_pos_off;
    logic                              pos_done;
    logic                              all_off;

    assign fault_any = fault.under_voltage_limit | fault.over_voltage_limit
                     | fault.seq_timeout;
    assign cmd_fs    = !cmd.force_shutdown_input_b | cmd.bus_fs_cmd;
    assign cmd_off   = !cmd.power_on_request_input | cmd.bus_off_cmd;
    assign supply_enable_output = ch_en;
    assign locked_out = state_reg == srp_pkg::ST_LOCKED;
    assign running    = state_reg == srp_pkg::ST_RUN;
    assign all_off    = ch_en == '0;

    ////////////////////////////////////////////////////////////////////////////
    // Cascade gating: a position may turn off only after every earlier position
    // measures off; equal positions are released together.
    always_comb begin
        prev_pos_off = 1'b1;
        pos_done     = 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
            if (off_pos[i] < pos_reg && !monitored_supply_input_off[i]) begin
                prev_pos_off = 1'b0;
            end
            if (off_pos[i] == pos_reg && ch_en[i]) begin
                pos_done = 1'b0;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            turn_on[i]  = state_reg == srp_pkg::ST_ON_DLY && on_pos[i] == pos_reg
                        && on_cnt_reg == '0;
            turn_off[i] = state_reg == srp_pkg::ST_OFF_SEQ && off_pos[i] == pos_reg
                        && prev_pos_off;
        end
    end

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        srp_ch_off #(
            .DLY_W (srp_pkg::DLY_W)
        ) u_ch (
            .clock      (clock),
            .rst_b      (rst_b),
            .turn_on    (turn_on[g]),
            .turn_off   (turn_off[g]),
            .kill       (fs_reg),
            .off_ok     (prev_pos_off),
            .off_dly    (off_dly[g]),
            .enable_reg (ch_en[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shutdown cause, force-shutdown pulse and retry count.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fault_cause_reg <= 1'b0;
            fs_reg          <= 1'b0;
        end else begin
            // A force-shutdown clears the enables in every state, also during a cascaded power-off.
            fs_reg <= cmd_fs | fault.seq_timeout;
            if (state_reg == srp_pkg::ST_RUN || state_reg == srp_pkg::ST_ON_DLY) begin
                if (cmd_fs) begin
                    fault_cause_reg <= 1'b0;
                end else if (fault_any) begin
                    fault_cause_reg <= 1'b1;
                end else if (cmd_off) begin
                    fault_cause_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            retry_count_reg <= '0;
        // Only a restart that really begins is counted, so a held-off restart is not counted every cycle.
        end else if (state_reg == srp_pkg::ST_RESTART && tmr_reg == '0 && fault_cause_reg
                     && !(retry_limit_en && retry_count_reg >= retry_limit)
                     && cmd.power_on_request_input && cmd.force_shutdown_input_b
                     && !cmd.bus_off_cmd && retry_count_reg != '1) begin
            retry_count_reg <= retry_count_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state, restart timer and power-on delay.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg  <= srp_pkg::ST_IDLE;
            tmr_reg    <= '0;
            on_cnt_reg <= '0;
            pos_reg    <= '0;
        end else begin
            case (state_reg)
                srp_pkg::ST_IDLE: begin
                    if (cmd.power_on_request_input && cmd.force_shutdown_input_b) begin
                        state_reg  <= srp_pkg::ST_ON_DLY;
                        pos_reg    <= '0;
                        on_cnt_reg <= on_dly[0];
                    end
                end
                srp_pkg::ST_ON_DLY: begin
                    if (cmd_fs || fault_any || cmd_off) begin
                        state_reg <= srp_pkg::ST_OFF_SEQ;
                        pos_reg   <= '0;
                    end else if (on_cnt_reg != '0) begin
                        on_cnt_reg <= on_cnt_reg - 1'b1;
                    end else if (pos_reg == srp_pkg::POS_W'(NUM_POS - 1)) begin
                        state_reg <= srp_pkg::ST_RUN;
                    end else begin
                        pos_reg    <= pos_reg + 1'b1;
                        on_cnt_reg <= on_dly[0];
                    end
                end
                srp_pkg::ST_RUN: begin
                    if (cmd_fs || fault_any || cmd_off) begin
                        state_reg <= srp_pkg::ST_OFF_SEQ;
                        pos_reg   <= '0;
                    end
                end
                srp_pkg::ST_OFF_SEQ: begin
                    if (all_off) begin
                        state_reg <= srp_pkg::ST_RESTART;
                        tmr_reg   <= fault_cause_reg ? srp_pkg::TMR_W'(FAULT_CYC)
                                                     : srp_pkg::TMR_W'(CMD_CYC);
                    end else if (pos_done && prev_pos_off
                                 && pos_reg != srp_pkg::POS_W'(NUM_POS - 1)) begin
                        pos_reg <= pos_reg + 1'b1;
                    end
                end
                srp_pkg::ST_RESTART: begin
                    if (tmr_reg != '0) begin
                        tmr_reg <= tmr_reg - 1'b1;
                    end else if (fault_cause_reg && retry_limit_en
                                 && retry_count_reg >= retry_limit) begin
                        state_reg <= srp_pkg::ST_LOCKED;
                    end else if (cmd.power_on_request_input && cmd.force_shutdown_input_b
                                 && !cmd.bus_off_cmd) begin
                        state_reg  <= srp_pkg::ST_ON_DLY;
                        pos_reg    <= '0;
                        on_cnt_reg <= on_dly[0];
                    end
                end
                srp_pkg::ST_LOCKED: begin
                    if (!cmd.power_on_request_input) begin
                        state_reg <= srp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= srp_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule : srp_policy

/* File: src/srp_pkg.sv */
// Shared constants and types for the supply restart policy block.
// Assumes a 40 MHz clock; all times are converted to cycle counts here.
package srp_pkg;

    localparam int           NUM_CH        = 6;
    localparam int           NUM_POS       = 8;
    localparam int           POS_W         = 3;
    localparam int           DLY_W         = 16;
    localparam int           RETRY_W       = 4;
    localparam longint       CLK_HZ        = 40000000;
    // Restart delays in their own units.
    localparam longint       FAULT_DLY_MS_X10 = 24000;
    localparam longint       CMD_DLY_US_X10   = 125000;
    localparam longint       FAULT_DLY_CYC = (FAULT_DLY_MS_X10 * CLK_HZ) / 10000;
    localparam longint       CMD_DLY_CYC   = (CMD_DLY_US_X10 * CLK_HZ) / 10000000;
    localparam int           TMR_W         = 27;
    localparam logic [2:0]   CAUSE_NONE    = 3'h0;

    typedef struct packed {
        logic under_voltage_limit;
        logic over_voltage_limit;
        logic seq_timeout;
    } srp_fault_t;

    typedef struct packed {
        logic force_shutdown_input_b;
        logic power_on_request_input;
        logic bus_off_cmd;
        logic bus_fs_cmd;
    } srp_cmd_t;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_ON_DLY  = 6'h02,
        ST_RUN     = 6'h04,
        ST_OFF_SEQ = 6'h08,
        ST_RESTART = 6'h10,
        ST_LOCKED  = 6'h20
    } srp_state_t;

endpackage : srp_pkg

/* File: src/srp_ch_off.sv */
// One channel's power-off delay and enable output stage.
// Assumes off_ok is a synchronous level from the monitor comparison.
`timescale 1ns/100ps
module srp_ch_off #(
    parameter int DLY_W = 16
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Control.
    input  wire logic             turn_on,
    input  wire logic             turn_off,
    input  wire logic             kill,
    input  wire logic             off_ok,
    input  wire logic [DLY_W-1:0] off_dly,
    // Result.
    output logic                  enable_reg
);
    logic [DLY_W-1:0] cnt_reg;
    logic             pend_reg;

    // Power-off delay counts from turn_off with off_ok high (earlier positions off) to dropping the enable.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            enable_reg <= 1'b0;
            pend_reg   <= 1'b0;
            cnt_reg    <= '0;
        end else if (kill) begin
            enable_reg <= 1'b0;
            pend_reg   <= 1'b0;
        end else if (turn_on) begin
            enable_reg <= 1'b1;
            pend_reg   <= 1'b0;
        end else if (turn_off && enable_reg && !pend_reg && off_ok) begin
            pend_reg <= 1'b1;
            cnt_reg  <= off_dly;
        end else if (pend_reg) begin
            if (cnt_reg == '0) begin
                enable_reg <= 1'b0;
                pend_reg   <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule : srp_ch_off

/* File: sim/srp_policy_checker.sv */
// Port checker for the restart policy block.
// Assumes it is bound onto srp_policy with short sim delays.
`timescale 1ns/100ps
module srp_policy_checker #(
    parameter int     NUM_CH    = 6,
    parameter longint FAULT_CYC = 200,
    parameter longint CMD_CYC   = 50
) (
    // Clock, reset and causes.
    input wire logic                                  clock,
    input wire logic                                  rst_b,
    input wire srp_pkg::srp_fault_t                   fault,
    input wire srp_pkg::srp_cmd_t                     cmd,
    // Configuration and supplies.
    input wire logic [NUM_CH-1:0][srp_pkg::POS_W-1:0] off_pos,
    input wire logic [NUM_CH-1:0][srp_pkg::DLY_W-1:0] on_dly,
    input wire logic                                  retry_limit_en,
    input wire logic [srp_pkg::RETRY_W-1:0]           retry_limit,
    input wire logic [NUM_CH-1:0]                     monitored_supply_input_off,
    // Outputs.
    input wire logic [NUM_CH-1:0]                     supply_enable_output,
    input wire logic                                  fault_cause_reg,
    input wire logic [srp_pkg::RETRY_W-1:0]           retry_count_reg,
    input wire logic                                  locked_out,
    input wire logic                                  running
);
    logic              fs_now;
    logic              seen_reg;
    int                zero_cnt_reg;
    logic [NUM_CH-1:0] prev_off;
    ////////////////////////////////////////////////////////////////////////
    assign fs_now = !cmd.force_shutdown_input_b || cmd.bus_fs_cmd || fault.seq_timeout;
    // A channel may drop only once every earlier off position measures off.
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            prev_off[i] = 1'b1;
            for (int j = 0; j < NUM_CH; j++)
                if (off_pos[j] < off_pos[i] && !monitored_supply_input_off[j]) prev_off[i] = 1'b0;
        end
    end
    // Counts cycles with every enable low, to time the restart.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) zero_cnt_reg <= 0;
        else if (supply_enable_output != '0) zero_cnt_reg <= 0;
        else if (zero_cnt_reg < 100000) zero_cnt_reg <= zero_cnt_reg + 1;
    end
    // Marks that a restart, not a first start, is pending.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) seen_reg <= 1'b0;
        else if (locked_out || !cmd.power_on_request_input) seen_reg <= 1'b0;
        else if (running) seen_reg <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    chk_fs_all_off:
    assert property (@(posedge clock) disable iff (!rst_b) fs_now |=> ##1 supply_enable_output == '0)
        else $error("enables not cleared by force shutdown");
    chk_fault_cause:
    assert property (@(posedge clock) disable iff (!rst_b) running && fault != '0 |=> fault_cause_reg)
        else $error("fault shutdown not marked as fault");
    chk_cmd_cause:
    assert property (@(posedge clock) disable iff (!rst_b) running && fault == '0 &&
        (cmd.bus_off_cmd || cmd.bus_fs_cmd || !cmd.force_shutdown_input_b || !cmd.power_on_request_input)
        |=> !fault_cause_reg)
        else $error("command shutdown marked as fault");
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        chk_cascade_order:
        assert property (@(posedge clock) disable iff (!rst_b)
            $fell(supply_enable_output[i]) && !$past(fs_now, 2) |-> $past(prev_off[i]))
            else $error("enable dropped before earlier position was off");
    end
    chk_restart_delay:
    assert property (@(posedge clock) disable iff (!rst_b) $rose(|supply_enable_output) && seen_reg |->
        zero_cnt_reg >= (fault_cause_reg ? FAULT_CYC : CMD_CYC) &&
        zero_cnt_reg <= (fault_cause_reg ? FAULT_CYC : CMD_CYC) + on_dly[0] + 8)
        else $error("restart delay out of window");
    chk_retry_cause:
    assert property (@(posedge clock) disable iff (!rst_b)
        $changed(retry_count_reg) && retry_count_reg != '0 |-> fault_cause_reg)
        else $error("retry counted after command shutdown");
    chk_retry_step:
    assert property (@(posedge clock) disable iff (!rst_b)
        $changed(retry_count_reg) && retry_count_reg != '0 |-> retry_count_reg == $past(retry_count_reg) + 4'h1)
        else $error("retry count did not step by one");
    chk_lock_limit:
    assert property (@(posedge clock) disable iff (!rst_b) locked_out |->
        retry_limit_en && retry_count_reg >= retry_limit && supply_enable_output == '0)
        else $error("lockout without reaching retry limit");
    cov_fault_restart: cover property (@(posedge clock) disable iff (!rst_b) fault_cause_reg && $rose(running));
    cov_cmd_restart: cover property (@(posedge clock) disable iff (!rst_b) !fault_cause_reg && $rose(running));
    cov_lockout: cover property (@(posedge clock) disable iff (!rst_b) $rose(locked_out));
endmodule : srp_policy_checker

bind srp_policy srp_policy_checker #(.NUM_CH(NUM_CH), .FAULT_CYC(FAULT_CYC), .CMD_CYC(CMD_CYC)) u_chk (
    .clock, .rst_b, .fault, .cmd, .off_pos, .on_dly, .retry_limit_en, .retry_limit,
    .monitored_supply_input_off, .supply_enable_output, .fault_cause_reg, .retry_count_reg,
    .locked_out, .running);

/* File: sim/srp_supply_model.sv */
// Behavioural model of the converters behind the supply enables.
// Assumes one clock; each output crosses its threshold a few cycles late.
`timescale 1ns/100ps
module srp_supply_model #(
    parameter int NUM_CH = 6
) (
    // Clock.
    input  wire logic              clock,
    // Converter side.
    input  wire logic [NUM_CH-1:0] enable,
    output logic      [NUM_CH-1:0] off_level
);
    logic [NUM_CH-1:0] lvl = '1;
    int                cnt [NUM_CH] = '{default: 0};
    assign off_level = lvl;
    // Channel pairs settle in 3, 4 and 5 cycles, so later pairs are slower.
    always_ff @(posedge clock) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (lvl[i] != enable[i]) cnt[i] <= 0;
            else if (cnt[i] >= 2 + i / 2) begin
                lvl[i] <= !enable[i];
                cnt[i] <= 0;
            end else cnt[i] <= cnt[i] + 1;
        end
    end
endmodule : srp_supply_model

/* File: sim/supply_restart_policy_tb.sv */
// Self-checking bench for the restart policy block.
// Assumes srp_policy, its checker and the converter model are compiled.
`timescale 1ns/100ps
module supply_restart_policy_tb;
    localparam longint FCYC = 200;
    localparam longint CCYC = 50;
    logic                          clock          = 1'b0;
    logic                          rst_b          = 1'b0;
    srp_pkg::srp_fault_t           fault          = '0;
    srp_pkg::srp_cmd_t             cmd            = 4'h8;
    logic                          retry_limit_en = 1'b0;
    logic [srp_pkg::RETRY_W-1:0]   retry_limit    = 4'h0;
    logic [5:0]                    mon_off;
    logic [5:0]                    en;
    logic                          fcause;
    logic                          locked;
    logic                          running;
    logic [srp_pkg::RETRY_W-1:0]   retry;
    int                            failures  = 0;
    int                            compares  = 0;
    int                            exp_retry = 0;
    always #12.5 clock = ~clock;
    srp_policy #(.FAULT_CYC(FCYC), .CMD_CYC(CCYC)) dut (
        .clock, .rst_b, .fault, .cmd, .on_pos(18'h12240), .off_pos(18'h12240),
        .on_dly({6{16'h0002}}), .off_dly({6{16'h0001}}), .retry_limit_en, .retry_limit,
        .monitored_supply_input_off(mon_off), .supply_enable_output(en),
        .fault_cause_reg(fcause), .retry_count_reg(retry), .locked_out(locked), .running);
    srp_supply_model u_model (.clock, .enable(en), .off_level(mon_off));
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic wait_en(input logic want_on, output int n);
        for (n = 0; (|en) !== want_on; n++) begin
            @(negedge clock);
            if (n > 2000) begin
                failures++;
                summarize();
            end
        end
    endtask : wait_en
    always @(negedge clock) begin
        if (rst_b && (en[0] !== en[1] || en[2] !== en[3] || en[4] !== en[5])) begin
            failures++;
            $display("Error pair_enables expected equal pairs seen %0h", en);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic power_up;
        int n;
        @(posedge clock);
        cmd <= 4'hc;
        wait_en(1'b1, n);
        check("first_position", 6'h03, en);
        for (n = 0; n < 200 && !running; n++) @(negedge clock);
        check("all_enabled", 6'h3f, en);
    endtask : power_up
    // Pulses one shutdown cause, then times the restart that follows.
    task automatic shut(input logic [2:0] f, input logic [3:0] c, input logic is_fault);
        int     n;
        longint d;
        d = is_fault ? FCYC : CCYC;
        @(posedge clock);
        fault <= f;
        cmd <= c;
        @(posedge clock);
        fault <= '0;
        cmd <= 4'hc;
        repeat (2) @(negedge clock);
        check("fault_cause", is_fault, fcause);
        if (!c[3] || c[0] || f[0]) check("enables_cleared", 6'h00, en);
        wait_en(1'b0, n);
        wait_en(1'b1, n);
        check("restart_window", 1, n >= d && n <= d + 8);
        if (is_fault) exp_retry++;
        check("retry_count", exp_retry, retry);
        for (n = 0; n < 200 && !running; n++) @(negedge clock);
        check("running_again", 1, running);
    endtask : shut
    task automatic lockout;
        int n;
        @(posedge clock);
        retry_limit_en <= 1'b1;
        retry_limit <= exp_retry[3:0];
        fault <= 3'h4;
        @(posedge clock);
        fault <= '0;
        for (n = 0; n < 2000 && !locked; n++) @(negedge clock);
        check("locked_out", 1, locked);
        check("locked_enables", 6'h00, en);
        @(posedge clock);
        cmd <= 4'h8;
        for (n = 0; n < 20 && locked; n++) @(negedge clock);
        check("unlocked", 0, locked);
    endtask : lockout
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        power_up();
        shut(3'h4, 4'hc, 1'b1);
        shut(3'h2, 4'hc, 1'b1);
        shut(3'h1, 4'hc, 1'b1);
        shut(3'h0, 4'h4, 1'b0);
        shut(3'h0, 4'he, 1'b0);
        shut(3'h0, 4'hd, 1'b0);
        shut(3'h0, 4'h8, 1'b0);
        lockout();
        summarize();
    end
endmodule : supply_restart_policy_tb
